//--- core/ddrp_pkg.sv
// Package: command codes, storage sizes and fixed positions of the DDR2 pin interface
package ddrp_pkg;
    // Command code, {rank_select_n, row_strobe_n, column_strobe_n, write_strobe_n}
    localparam logic [3:0] DDRP_CMD_CONFIG = 4'h0;
    localparam logic [3:0] DDRP_CMD_READ = 4'h5;
    localparam logic [3:0] DDRP_CMD_WRITE = 4'h4;
    // Bank code that selects extended_config_one
    localparam logic [2:0] DDRP_BANK_EXT_ONE = 3'h1;
    // Address bit that steers the complementary strobes
    localparam int DDRP_STROBE_MODE_BIT = 10;
    // Level of that bit that enables differential strobe mode
    localparam logic DDRP_STROBE_DIFF_LEVEL = 1'h0;
    localparam logic DDRP_STROBE_MODE_RST = 1'h1;
    // Storage: words of 16 bits, addressed by the low column bits
    localparam int DDRP_ADDR_W = 4;
    localparam int DDRP_DEPTH = 16;
    localparam logic [15:0] DDRP_WORD_RST = 16'h0000;
    // Byte lanes
    localparam int DDRP_LOW_LSB = 0;
    localparam int DDRP_UP_LSB = 8;
    typedef logic [DDRP_ADDR_W-1:0] ddrp_addr_t;
endpackage

//--- core/ddrp_core.sv
// Device-side command, mask, strobe and data pin logic of a x16 DDR2 memory
// Summary of operation
// RL1: Upper complementary strobe only in differential mode
// RL2: Rank select high masks every command
// RL3: Command decoded from all four strobe lines
// RL4: Masked write beats leave storage unchanged
// RL5: Write mask sampled on both strobe edges; the code samples it on both clk_mem edges
// RL6: Commands sampled on rising clock crossing
// RL7: Read data on both clock crossings
// RL8: Clock gate enable sampled high enables clocking
// RL9: Strobe edge-aligned with read data
// RL10: Lower byte strobe serves data 0-7
// RL11: Each mask applies to its own byte
`timescale 1ns/10ps
module ddrp_core
    import ddrp_pkg::*;
(
    // System side
    input wire logic clk_sys,
    input wire logic rst,
    output logic sys_strobe_diff_mode,
    output logic sys_clock_gated,
    output logic sys_write_done,
    output logic sys_read_done,
    // Memory clock and command pins
    input wire logic clk_mem,
    input wire logic clock_gate_enable,
    input wire logic rank_select_n,
    input wire logic row_strobe_n,
    input wire logic column_strobe_n,
    input wire logic write_strobe_n,
    input wire logic [2:0] bank,
    input wire logic [12:0] addr,
    // Data and masks
    input wire logic upper_write_mask,
    input wire logic lower_write_mask,
    input wire logic [15:0] dq_i,
    output logic [15:0] dq_o,
    output logic dq_oe,
    // Strobes
    output logic lower_byte_strobe_o,
    output logic lower_byte_strobe_oe,
    output logic lower_byte_strobe_n_o,
    output logic lower_byte_strobe_n_oe,
    output logic upper_byte_strobe_o,
    output logic upper_byte_strobe_oe,
    output logic upper_byte_strobe_n_o,
    output logic upper_byte_strobe_n_oe
);
    function automatic logic [15:0] ddrp_merge(input logic [15:0] old_w,
        input logic [15:0] new_w, input logic up_m, input logic low_m);
        logic [15:0] res;
        res = old_w;
        if (!low_m) res[DDRP_LOW_LSB+:8] = new_w[DDRP_LOW_LSB+:8];
        if (!up_m) res[DDRP_UP_LSB+:8] = new_w[DDRP_UP_LSB+:8];
        return res;
    endfunction

    // Reset carried into the memory clock domain
    logic mrst_meta_reg, mrst_reg;
    always_ff @(posedge clk_mem) begin
        mrst_meta_reg <= rst;
        mrst_reg <= mrst_meta_reg;
    end

    // Command decode on the rising crossing
    logic [3:0] cmd_code;
    logic cke_reg, strobe_mode_reg;
    logic wr_cmd, rd_cmd;
    assign cmd_code = {rank_select_n, row_strobe_n, column_strobe_n, write_strobe_n}; // [RL3]
    assign wr_cmd = clock_gate_enable && cmd_code == DDRP_CMD_WRITE; // [RL2] [RL8]
    assign rd_cmd = clock_gate_enable && cmd_code == DDRP_CMD_READ; // [RL2] [RL8]

    always_ff @(posedge clk_mem) begin
        if (mrst_reg) begin
            cke_reg <= 1'b0;
        end else begin
            cke_reg <= clock_gate_enable; // [RL8]
        end
    end

    always_ff @(posedge clk_mem) begin
        if (mrst_reg) begin
            strobe_mode_reg <= DDRP_STROBE_MODE_RST;
        end else if (clock_gate_enable && cmd_code == DDRP_CMD_CONFIG
                && bank == DDRP_BANK_EXT_ONE) begin
            strobe_mode_reg <= addr[DDRP_STROBE_MODE_BIT]; // [RL1]
        end
    end

    // Write path: capture at N+1 both edges, commit at N+2
    logic wr_cap_reg, wr_commit_reg;
    ddrp_addr_t wr_addr_reg, rd_addr_reg;
    logic [15:0] beat0_reg, beat1_reg;
    logic [1:0] mask0_reg, mask1_reg;
    logic [15:0] mem_reg [DDRP_DEPTH];

    always_ff @(posedge clk_mem) begin
        if (mrst_reg) begin
            wr_cap_reg <= 1'b0;
            wr_commit_reg <= 1'b0;
            wr_addr_reg <= '0;
        end else begin
            wr_cap_reg <= wr_cmd; // [RL6]
            wr_commit_reg <= wr_cap_reg;
            if (wr_cmd) wr_addr_reg <= addr[DDRP_ADDR_W-1:0];
        end
    end

    always_ff @(posedge clk_mem) begin
        if (mrst_reg) begin
            beat0_reg <= DDRP_WORD_RST;
            mask0_reg <= 2'h3;
        end else if (wr_cap_reg) begin
            beat0_reg <= dq_i;
            mask0_reg <= {upper_write_mask, lower_write_mask}; // [RL5]
        end
    end

    always_ff @(negedge clk_mem) begin
        if (mrst_reg) begin
            beat1_reg <= DDRP_WORD_RST;
            mask1_reg <= 2'h3;
        end else if (wr_commit_reg) begin
            beat1_reg <= dq_i;
            mask1_reg <= {upper_write_mask, lower_write_mask}; // [RL5]
        end
    end

    always_ff @(posedge clk_mem) begin
        if (mrst_reg) begin
            for (int i = 0; i < DDRP_DEPTH; i++) mem_reg[i] <= DDRP_WORD_RST;
        end else if (wr_commit_reg) begin
            mem_reg[wr_addr_reg] <= ddrp_merge(mem_reg[wr_addr_reg], beat0_reg,
                mask0_reg[1], mask0_reg[0]); // [RL4] [RL11]
            mem_reg[wr_addr_reg + 1'b1] <= ddrp_merge(mem_reg[wr_addr_reg + 1'b1],
                beat1_reg, mask1_reg[1], mask1_reg[0]); // [RL4] [RL11]
        end
    end

    // Read path: one cycle after the command, two beats per clock
    logic rd_pend_reg, drive_reg, drive_n_reg;
    logic [15:0] out_pos_reg, out_neg_reg;
    always_ff @(posedge clk_mem) begin
        if (mrst_reg) begin
            rd_pend_reg <= 1'b0;
            rd_addr_reg <= '0;
        end else begin
            rd_pend_reg <= rd_cmd; // [RL6]
            if (rd_cmd) rd_addr_reg <= addr[DDRP_ADDR_W-1:0];
        end
    end

    always_ff @(posedge clk_mem) begin
        if (mrst_reg) begin
            drive_reg <= 1'b0;
            out_pos_reg <= DDRP_WORD_RST;
        end else begin
            drive_reg <= rd_pend_reg;
            if (rd_pend_reg) out_pos_reg <= mem_reg[rd_addr_reg]; // [RL7]
        end
    end

    always_ff @(negedge clk_mem) begin
        if (mrst_reg) begin
            drive_n_reg <= 1'b0;
            out_neg_reg <= DDRP_WORD_RST;
        end else begin
            drive_n_reg <= drive_reg;
            if (drive_reg) out_neg_reg <= mem_reg[rd_addr_reg + 1'b1]; // [RL7]
        end
    end

    // Beat select follows the clock level; strobe pulses once, low in the trailing half
    logic drive;
    assign drive = drive_reg || drive_n_reg;
    assign dq_o = clk_mem ? out_pos_reg : out_neg_reg; // [RL7]
    assign dq_oe = drive;
    assign lower_byte_strobe_o = clk_mem && drive_reg; // [RL9] [RL10]
    assign lower_byte_strobe_oe = drive; // [RL10]
    assign upper_byte_strobe_o = clk_mem && drive_reg; // [RL9]
    assign upper_byte_strobe_oe = drive;
    assign lower_byte_strobe_n_o = !(clk_mem && drive_reg);
    assign lower_byte_strobe_n_oe = drive && strobe_mode_reg == DDRP_STROBE_DIFF_LEVEL;
    assign upper_byte_strobe_n_o = !(clk_mem && drive_reg);
    assign upper_byte_strobe_n_oe = drive && strobe_mode_reg == DDRP_STROBE_DIFF_LEVEL; // [RL1]

    // Events to the system domain by toggle, levels by two flip-flops
    logic wr_tgl_reg, rd_tgl_reg;
    always_ff @(posedge clk_mem) begin
        if (mrst_reg) begin
            wr_tgl_reg <= 1'b0;
            rd_tgl_reg <= 1'b0;
        end else begin
            if (wr_commit_reg) wr_tgl_reg <= !wr_tgl_reg;
            if (rd_pend_reg) rd_tgl_reg <= !rd_tgl_reg;
        end
    end

    logic [3:0] sync1_reg, sync2_reg;
    logic [1:0] tgl_old_reg;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sync1_reg <= 4'h0;
            sync2_reg <= 4'h0;
            tgl_old_reg <= 2'h0;
        end else begin
            sync1_reg <= {wr_tgl_reg, rd_tgl_reg,
                strobe_mode_reg == DDRP_STROBE_DIFF_LEVEL, cke_reg};
            sync2_reg <= sync1_reg;
            tgl_old_reg <= sync2_reg[3:2];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sys_write_done <= 1'b0;
            sys_read_done <= 1'b0;
            sys_strobe_diff_mode <= 1'b0;
            sys_clock_gated <= 1'b1;
        end else begin
            sys_write_done <= sync2_reg[3] ^ tgl_old_reg[1];
            sys_read_done <= sync2_reg[2] ^ tgl_old_reg[0];
            sys_strobe_diff_mode <= sync2_reg[1];
            sys_clock_gated <= !sync2_reg[0];
        end
    end

    // Checks on the memory clock domain, off while rst or the carried reset is high
    sequence s_write_cmd;
        clock_gate_enable && cmd_code == DDRP_CMD_WRITE;
    endsequence
    sequence s_read_cmd;
        clock_gate_enable && cmd_code == DDRP_CMD_READ;
    endsequence

    property p_rank_mask;
        @(posedge clk_mem) disable iff (mrst_reg || rst)
        rank_select_n |=> !wr_cap_reg && !rd_pend_reg;
    endproperty
    a_rank_mask: assert property (p_rank_mask) else $error("command taken while deselected"); // [RL2]

    property p_write_decode;
        @(posedge clk_mem) disable iff (mrst_reg || rst)
        s_write_cmd |=> wr_cap_reg ##1 wr_commit_reg;
    endproperty
    a_write_decode: assert property (p_write_decode) else $error("write not decoded"); // [RL3]

    property p_read_rise;
        @(posedge clk_mem) disable iff (mrst_reg || rst)
        s_read_cmd ##1 rd_pend_reg |=> drive_reg && dq_oe;
    endproperty
    a_read_rise: assert property (p_read_rise) else $error("read data not driven"); // [RL6]

    property p_read_two_beats;
        @(posedge clk_mem) disable iff (mrst_reg || rst)
        s_read_cmd |=> ##1 out_pos_reg == $past(mem_reg[addr[DDRP_ADDR_W-1:0]], 2)
            && out_neg_reg == $past(mem_reg[addr[DDRP_ADDR_W-1:0] + 1'b1], 2);
    endproperty
    a_read_two_beats: assert property (p_read_two_beats) else $error("wrong read beat"); // [RL7]

    property p_gate_low;
        @(posedge clk_mem) disable iff (mrst_reg || rst)
        !clock_gate_enable |=> !wr_cap_reg && !rd_pend_reg && !cke_reg;
    endproperty
    a_gate_low: assert property (p_gate_low) else $error("command taken while gated"); // [RL8]

    property p_mask_upper;
        @(posedge clk_mem) disable iff (mrst_reg || rst)
        wr_commit_reg && mask0_reg[1] && wr_addr_reg != wr_addr_reg + 1'b1
        |=> mem_reg[$past(wr_addr_reg)][15:8] == $past(mem_reg[wr_addr_reg][15:8]);
    endproperty
    a_mask_upper: assert property (p_mask_upper) else $error("masked upper byte written"); // [RL4]

    property p_mask_lower_beat1;
        @(posedge clk_mem) disable iff (mrst_reg || rst)
        wr_commit_reg && !mask1_reg[0] |=> mem_reg[$past(wr_addr_reg) + 1'b1][7:0]
            == $past(beat1_reg[7:0]);
    endproperty
    a_mask_lower_beat1: assert property (p_mask_lower_beat1) else $error("lower beat lost"); // [RL5]

    property p_upper_complement;
        @(posedge clk_mem) disable iff (mrst_reg || rst)
        strobe_mode_reg != DDRP_STROBE_DIFF_LEVEL |-> !upper_byte_strobe_n_oe;
    endproperty
    a_upper_complement: assert property (p_upper_complement) else $error("complement in single mode"); // [RL1]

    property p_lower_strobe_lane;
        @(posedge clk_mem) disable iff (mrst_reg || rst)
        lower_byte_strobe_oe == dq_oe;
    endproperty
    a_lower_strobe_lane: assert property (p_lower_strobe_lane) else $error("lower strobe not with data"); // [RL10]
endmodule // ddrp_core

//--- bench/ddrp_ctrl_model.sv
// Memory controller model driving the DDR2 command, mask and data pins
`timescale 1ns/10ps
module ddrp_ctrl_model
    import ddrp_pkg::*;
(
    // Link clock
    input wire logic clk_mem,
    // Command pins
    output logic clock_gate_enable,
    output logic [3:0] cmd,
    output logic [2:0] bank,
    output logic [12:0] addr,
    // Data, masks and strobes
    output logic [1:0] mask,
    output logic [15:0] dq,
    input wire logic [15:0] dq_o,
    input wire logic dq_oe,
    input wire logic [7:0] strb
);
    initial begin
        {clock_gate_enable, cmd, bank, addr, mask, dq} = {1'h1, 4'hF, 34'h0};
    end
    // Command then two beats; released command lines go high, bank, address, data and mask are inverted
    task automatic burst(input logic [3:0] c, input logic [2:0] b, input logic [12:0] a,
        input logic ce, input logic [15:0] d0, input logic [15:0] d1,
        input logic [1:0] m0, input logic [1:0] m1);
        @(negedge clk_mem);
        {cmd, bank, addr, clock_gate_enable} = {c, b, a, ce};
        @(negedge clk_mem);
        {cmd, bank, addr, dq, mask} = {4'hF, ~b, ~a, d0, m0};
        @(posedge clk_mem);
        #1 {dq, mask} = {d1, m1};
        @(negedge clk_mem);
        #1 {dq, mask} = {~d1, ~m1};
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] ba, output logic [15:0] bb,
        output logic [7:0] sa, output logic [7:0] sb);
        @(negedge clk_mem);
        {cmd, bank, addr, clock_gate_enable} = {DDRP_CMD_READ, 3'h0, 9'h0, a, 1'h1};
        @(negedge clk_mem);
        {cmd, addr} = {4'hF, ~addr};
        @(posedge clk_mem);
        #10 {ba, sa} = {dq_o, strb};
        @(negedge clk_mem);
        #10 {bb, sb} = {dq_o, strb};
        repeat (2) @(posedge clk_mem);
    endtask
endmodule // ddrp_ctrl_model

//--- bench/testbench.sv
// Self-checking bench of the DDR2 pin logic against a behavioural memory model
`timescale 1ns/10ps
`define CHECK(g, e) begin check_count++; if ((g) !== (e)) begin fail_count++; \
    $display("MISMATCH %0t got %0h exp %0h", $time, g, e); end end
module testbench;
    import ddrp_pkg::*;
    logic clk_sys = 0, clk_mem = 0, rst = 1, ce, strobe_diff, gated, wr_done, rd_done, dq_oe;
    logic [3:0] cmd, wa;
    logic [7:0] sa, sb;
    wire [7:0] strb;
    logic [2:0] bank;
    logic [12:0] addr;
    logic [1:0] mask;
    logic [15:0] dq, dq_o, ba, bb;
    logic [15:0] mem_m [DDRP_DEPTH];
    logic diff_m = 0;
    int fail_count = 0, check_count = 0, seed = 19888, cyc = 0, n_wr = 0, n_rd = 0;
    int wr_cnt = 0, rd_cnt = 0;
    logic [3:0] codes [3] = '{4'hC, 4'h6, 4'h7};
    logic [15:0] cfg [3] = '{16'h1000, 16'h0400, 16'h1400};
    always #50 clk_sys = ~clk_sys;
    always #62.5 clk_mem = ~clk_mem;
    ddrp_core ddrp_core_i (.clk_sys(clk_sys), .rst(rst), .sys_strobe_diff_mode(strobe_diff),
        .sys_clock_gated(gated), .sys_write_done(wr_done), .sys_read_done(rd_done),
        .clk_mem(clk_mem), .clock_gate_enable(ce), .rank_select_n(cmd[3]),
        .row_strobe_n(cmd[2]), .column_strobe_n(cmd[1]), .write_strobe_n(cmd[0]),
        .bank(bank), .addr(addr), .upper_write_mask(mask[1]), .lower_write_mask(mask[0]),
        .dq_i(dq), .dq_o(dq_o), .dq_oe(dq_oe), .lower_byte_strobe_o(strb[3]),
        .lower_byte_strobe_oe(strb[2]), .lower_byte_strobe_n_o(strb[5]),
        .lower_byte_strobe_n_oe(strb[0]), .upper_byte_strobe_o(strb[7]),
        .upper_byte_strobe_oe(strb[6]), .upper_byte_strobe_n_o(strb[4]),
        .upper_byte_strobe_n_oe(strb[1]));
    ddrp_ctrl_model ddrp_ctrl_model_i (.clk_mem(clk_mem), .clock_gate_enable(ce), .cmd(cmd),
        .bank(bank), .addr(addr), .mask(mask), .dq(dq), .dq_o(dq_o), .dq_oe(dq_oe), .strb(strb));
    always @(negedge clk_sys) begin
        wr_cnt += (wr_done === 1'b1);
        rd_cnt += (rd_done === 1'b1);
        cyc++;
        if (cyc == 5000) begin
            fail_count++;
            test_done();
        end
    end
    task automatic do_burst(input logic [3:0] c, input logic [2:0] b, input logic [12:0] a,
        input logic e, input logic [15:0] d0, input logic [15:0] d1,
        input logic [1:0] m0, input logic [1:0] m1);
        logic [3:0] i;
        ddrp_ctrl_model_i.burst(c, b, a, e, d0, d1, m0, m1);
        i = a[3:0];
        if (c == DDRP_CMD_WRITE && e) begin
            n_wr++;
            if (!m0[1]) mem_m[i][15:8] = d0[15:8];
            if (!m0[0]) mem_m[i][7:0] = d0[7:0];
            i = i + 4'h1;
            if (!m1[1]) mem_m[i][15:8] = d1[15:8];
            if (!m1[0]) mem_m[i][7:0] = d1[7:0];
        end
        if (c == DDRP_CMD_CONFIG && e && b == DDRP_BANK_EXT_ONE)
            diff_m = (a[DDRP_STROBE_MODE_BIT] == DDRP_STROBE_DIFF_LEVEL);
    endtask
    task automatic check_rd(input logic [3:0] a);
        ddrp_ctrl_model_i.rd(a, ba, bb, sa, sb);
        n_rd++;
        `CHECK(ba, mem_m[a])
        `CHECK(bb, mem_m[a + 4'h1])
        `CHECK(sa, {6'h33, diff_m, diff_m})
        `CHECK(sb, {6'h1D, diff_m, diff_m})
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        foreach (mem_m[k]) mem_m[k] = DDRP_WORD_RST;
        repeat (8) @(posedge clk_sys);
        @(negedge clk_sys);
        `CHECK({gated, strobe_diff, dq_oe, strb[2]}, 4'h8)
        rst = 0;
        repeat (4) @(posedge clk_mem);
        for (int i = 0; i < 12; i++) begin
            wa = (i == 0) ? 4'hF : 4'($random(seed));
            do_burst(DDRP_CMD_WRITE, 3'h0, {9'h0, wa}, 1'b1, 16'($random(seed)),
                16'($random(seed)), 2'($random(seed)), 2'($random(seed)));
            check_rd(wa);
        end
        foreach (codes[k]) begin
            do_burst(codes[k], 3'h0, 13'h3, 1'b1, 16'($random(seed)), 16'($random(seed)),
                2'h0, 2'h0);
            check_rd(4'h3);
        end
        do_burst(DDRP_CMD_WRITE, 3'h0, 13'h3, 1'b0, 16'($random(seed)), 16'($random(seed)),
            2'h0, 2'h0);
        repeat (6) @(negedge clk_sys);
        `CHECK(gated, 1'b1)
        check_rd(4'h3);
        repeat (6) @(negedge clk_sys);
        `CHECK(gated, 1'b0)
        foreach (cfg[k]) begin
            do_burst(DDRP_CMD_CONFIG, cfg[k][14:12], cfg[k][12:0], 1'b1, 16'h0000, 16'h0000,
                2'h0, 2'h0);
            repeat (6) @(negedge clk_sys);
            `CHECK(strobe_diff, diff_m)
            check_rd(4'h5);
        end
        repeat (10) @(negedge clk_sys);
        `CHECK(wr_cnt, n_wr)
        `CHECK(rd_cnt, n_rd)
        test_done();
    end
endmodule // testbench
